// >>> rtl/mbic_core.sv
/*
  Bus control and exception sequencer of an 8-bit processor with 128-byte
  on-chip RAM, plus the programmer registers on an APB slave.
  Assumes asynchronous pins (synchronised here) and an APB master on pclk.
*/
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - halt low: stop after instruction, release bus
// - read/write high for read, idle, halt
// - address strobe only with valid address
// - bus released high in halt or wait
// - wait ends on unmasked or non-maskable request
// - maskable level checked at boundary, stack registers
// - set mask, fetch vector fff8/fff9
// - service only while halt high, keep pending
// - restart low: inactive, then restart sequence
// - restart fetches fffe/ffff, sets mask
// - non-maskable falling edge ignores mask, stacks
// - non-maskable vector from fffc/fffd
// - sample requests in E high phase
// - mask at bit 4, bits 7:6 ones
// - arithmetic sets flags, branches test them
// - on-chip RAM only while enable high
// - 128 byte RAM, all 128 retained while enable low
// - stack points free slot, counter current
// - three 16-bit and three 8-bit registers
// - memory wait low stretches E high
module mbic_core
  import mbic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        halt_n,
  input  wire logic        irq_n,
  input  wire logic        nmi_n,
  input  wire logic        restart_n,
  input  wire logic        memory_wait_in,
  input  wire logic        onchip_memory_enable,
  input  wire logic [7:0]  data_in,
  output mbic_bus_s        bus_o
);

  // ==========================================================================
  // state and memory
  mbic_regs_s r;
  mbic_regs_s n;
  logic [7:0] ram [RAM_DEPTH];

  logic       halt_s;
  logic       irq_s;
  logic       nmi_s;
  logic       rst_s;
  logic       mw_s;
  logic       re_s;
  logic [7:0] din_s;
  logic       tick;
  logic       cycle_end;
  logic       onchip;
  logic [7:0] rdata;
  logic       ram_we;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic       apb_wr;
  logic       apb_setup;

  assign halt_s    = r.s2[SY_HALT];
  assign irq_s     = r.s2[SY_IRQ];
  assign nmi_s     = r.s2[SY_NMI];
  assign rst_s     = r.s2[SY_RST];
  assign mw_s      = r.s2[SY_MW];
  assign re_s      = r.s2[SY_RE];
  assign din_s     = r.s2[SY_DIN +: 8];
  assign tick      = (r.div == E_HALF_CYC - 8'h01);
  assign cycle_end = tick && r.e && mw_s;
  assign onchip    = (r.addr < RAM_LIMIT) && re_s;
  assign rdata     = onchip ? ram[r.addr[6:0]] : din_s;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;

  // ==========================================================================
  // helpers
  // stacking order
  function automatic logic [7:0] push_byte(input logic [2:0] i, input mbic_regs_s x);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      3'h0: v = x.pc[7:0];
      3'h1: v = x.pc[15:8];
      3'h2: v = x.ix[7:0];
      3'h3: v = x.ix[15:8];
      3'h4: v = x.a;
      3'h5: v = x.b;
      default: v = {CC_TOP_ONES, x.cc};
    endcase
    return v;
  endfunction : push_byte

  // instruction boundary: halt, pending requests, else next fetch
  function automatic mbic_regs_s boundary(input mbic_regs_s x, input logic hlt,
                                          input logic irq);
    mbic_regs_s y;
    y      = x;
    y.rw   = 1'b1;
    y.doe  = 1'b0;
    y.addr = x.pc;
    if (!hlt) begin
      y.st  = S_HALT;
      y.valid_address_strobe = 1'b0;
    end else if (x.nmi_pend || (!irq && !x.cc[CC_I])) begin
      y.vec      = x.nmi_pend ? VEC_NMI : VEC_IRQ;
      y.nmi_pend = 1'b0;
      y.st       = S_PUSH;
      y.idx      = 3'h0;
      y.addr     = x.sp;
      y.rw       = 1'b0;
      y.doe      = 1'b1;
      y.valid_address_strobe      = 1'b1;
      y.dout     = push_byte(3'h0, x);
    end else begin
      y.st  = S_FETCH;
      y.valid_address_strobe = 1'b1;
    end
    return y;
  endfunction : boundary

  // ==========================================================================
  // next state
  always_comb begin
    logic [8:0] sum;
    logic [4:0] hsum;
    sum    = 9'h000;
    hsum   = 5'h00;
    n      = r;
    ram_we = 1'b0;
    ram_wa = r.addr[6:0];
    ram_wd = r.dout;
    n.s1   = {data_in, onchip_memory_enable, memory_wait_in, restart_n, nmi_n,
              irq_n, halt_n};
    n.s2   = r.s1;
    n.div  = tick ? 8'h00 : r.div + 8'h01;
    if (tick && !(r.e && !mw_s)) begin
      n.e = !r.e;
    end
    if (tick && r.e) begin
      n.nmi_prev = nmi_s;
    end
    if (!rst_s) begin
      n.st   = S_RST;
      n.valid_address_strobe  = 1'b0;
      n.rw   = 1'b1;
      n.doe  = 1'b0;
      n.addr = VEC_RESTART;
    end else if (cycle_end) begin
      unique case (r.st)
        S_RST: begin
          n.st    = S_VEC_HI;
          n.vec   = VEC_RESTART;
          n.addr  = VEC_RESTART;
          n.valid_address_strobe   = 1'b1;
          n.cc[CC_I] = 1'b1;
        end
        S_VEC_HI: begin
          n.pc[15:8] = rdata;
          n.addr     = r.vec + 16'h0001;
          n.st       = S_VEC_LO;
        end
        S_VEC_LO: begin
          n.pc   = {r.pc[15:8], rdata};
          n.addr = {r.pc[15:8], rdata};
          n.st   = S_FETCH;
        end
        S_FETCH: begin
          n.pc = r.pc + 16'h0001;
          if (rdata == OP_WAIT) begin
            n.st  = S_WAIT;
            n.valid_address_strobe = 1'b0;
          end else if (rdata == OP_BR_ZERO) begin
            n.st   = S_OPER;
            n.addr = r.pc + 16'h0001;
          end else begin
            if (rdata == OP_ADD_BA) begin
              sum  = {1'b0, r.a} + {1'b0, r.b};
              hsum = {1'b0, r.a[3:0]} + {1'b0, r.b[3:0]};
              n.a        = sum[7:0];
              n.cc[CC_C] = sum[8];
              n.cc[CC_H] = hsum[4];
              n.cc[CC_N] = sum[7];
              n.cc[CC_Z] = (sum[7:0] == 8'h00);
              n.cc[CC_V] = (r.a[7] == r.b[7]) && (sum[7] != r.a[7]);
            end
            n = boundary(n, halt_s, irq_s);
          end
        end
        S_OPER: begin
          n.pc = r.pc + 16'h0001;
          if (r.cc[CC_Z]) begin
            n.pc = r.pc + 16'h0001 + {{8{rdata[7]}}, rdata};
          end
          n = boundary(n, halt_s, irq_s);
        end
        S_PUSH: begin
          n.sp   = r.sp - 16'h0001;
          ram_we = onchip;
          if (r.idx == PUSH_LAST) begin
            n.cc[CC_I] = 1'b1;
            n.st   = S_VEC_HI;
            n.addr = r.vec;
            n.rw   = 1'b1;
            n.doe  = 1'b0;
          end else begin
            n.idx  = r.idx + 3'h1;
            n.addr = r.sp - 16'h0001;
            n.dout = push_byte(r.idx + 3'h1, r);
          end
        end
        S_HALT: begin
          if (halt_s) begin
            n = boundary(n, halt_s, irq_s);
          end
        end
        S_WAIT: begin
          if (halt_s && (r.nmi_pend || (!irq_s && !r.cc[CC_I]))) begin
            n = boundary(n, halt_s, irq_s);
          end
        end
      endcase
    end
    if (tick && r.e && r.nmi_prev && !nmi_s) begin
      n.nmi_pend = 1'b1;
    end
    // apb setup phase captures read data
    if (apb_setup) begin
      n.perr   = 1'b0;
      n.prdata = 32'h0000_0000;
      if (paddr[11:9] == RAM_WIN_SEL) begin
        n.perr   = !re_s;
        n.prdata = re_s ? {24'h000000, ram[paddr[8:2]]} : 32'h0000_0000;
      end else begin
        unique case (paddr)
          OFS_INSTR_PTR:  n.prdata = {16'h0000, r.pc};
          OFS_STACK_TOP:  n.prdata = {16'h0000, r.sp};
          OFS_INDEX_BASE: n.prdata = {16'h0000, r.ix};
          OFS_ACC_A:      n.prdata = {24'h000000, r.a};
          OFS_ACC_B:      n.prdata = {24'h000000, r.b};
          OFS_COND_FLAGS: n.prdata = {24'h000000, CC_TOP_ONES, r.cc};
          OFS_STATUS: begin
            n.prdata[ST_STATE_LSB +: 3] = r.st;
            n.prdata[ST_BA]             = bus_o.ba;
            n.prdata[ST_VMA]            = r.valid_address_strobe;
            n.prdata[ST_NMI_PEND]       = r.nmi_pend;
            n.prdata[ST_HALT_REQ]       = !halt_s;
            n.prdata[ST_IRQ_REQ]        = !irq_s;
          end
          default: n.perr = 1'b1;
        endcase
      end
    end
    if (apb_wr) begin
      if (paddr[11:9] == RAM_WIN_SEL) begin
        // a stacking write to on-chip RAM keeps the port
        if (!ram_we) begin
          ram_we = re_s;
          ram_wa = paddr[8:2];
          ram_wd = pwdata[7:0];
        end
      end else begin
        unique case (paddr)
          OFS_INSTR_PTR:  n.pc = pwdata[15:0];
          OFS_STACK_TOP:  n.sp = pwdata[15:0];
          OFS_INDEX_BASE: n.ix = pwdata[15:0];
          OFS_ACC_A:      n.a  = pwdata[7:0];
          OFS_ACC_B:      n.b  = pwdata[7:0];
          OFS_COND_FLAGS: n.cc = pwdata[5:0];
          default: ;
        endcase
      end
    end
    if (n.st == S_HALT) begin
      n.addr = n.pc;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.st       <= S_RST;
      r.rw       <= 1'b1;
      r.nmi_prev <= 1'b1;
      r.s1       <= SYNC_RST;
      r.s2       <= SYNC_RST;
      r.addr     <= VEC_RESTART;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge pclk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  // ==========================================================================
  // outputs
  assign pready  = 1'b1;
  assign prdata  = r.prdata;
  assign pslverr = psel && penable && r.perr;

  always_comb begin
    bus_o      = '0;
    bus_o.addr = r.addr;
    bus_o.dout = r.dout;
    // bus released in halt or wait
    bus_o.ba   = (r.st == S_HALT) || (r.st == S_WAIT);
    bus_o.doe  = r.doe && !bus_o.ba;
    bus_o.rw   = r.rw || bus_o.ba;
    bus_o.valid_address_strobe  = r.valid_address_strobe && !bus_o.ba && (r.st != S_RST);
    bus_o.e    = r.e;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_push_last;
    r.st == S_PUSH && r.idx == PUSH_LAST && cycle_end && rst_s;
  endsequence
  sequence s_vec_start;
    r.st == S_VEC_HI && r.cc[CC_I] && r.addr == r.vec;
  endsequence

  property p_halt_release;
    r.st == S_HALT |-> bus_o.ba && !bus_o.valid_address_strobe && !bus_o.doe && bus_o.rw
                       && bus_o.addr == r.pc;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt bus state wrong");

  property p_rw_read;
    r.st != S_PUSH |-> bus_o.rw && !bus_o.doe;
  endproperty
  a_rw_read: assert property (p_rw_read) else $error("write level outside stacking");

  property p_vma_valid;
    bus_o.valid_address_strobe |-> r.st inside {S_VEC_HI, S_VEC_LO, S_FETCH, S_OPER, S_PUSH};
  endproperty
  a_vma_valid: assert property (p_vma_valid) else $error("strobe without valid address");

  property p_wait_exit;
    r.st == S_WAIT && cycle_end && rst_s && halt_s
      && (r.nmi_pend || (!irq_s && !r.cc[CC_I])) |=> r.st == S_PUSH;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait not left on request");

  property p_wait_masked;
    r.st == S_WAIT && cycle_end && rst_s && !r.nmi_pend && r.cc[CC_I] |=> r.st == S_WAIT;
  endproperty
  a_wait_masked: assert property (p_wait_masked) else $error("masked request left wait");

  property p_mask_then_vector;
    s_push_last |=> s_vec_start ##0 (r.vec == VEC_IRQ || r.vec == VEC_NMI);
  endproperty
  a_mask_then_vector: assert property (p_mask_then_vector) else $error("vector entry wrong");

  property p_halt_holds;
    r.st == S_HALT && !halt_s && rst_s |=> r.st == S_HALT;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("serviced while halted");

  property p_restart_vector;
    $rose(rst_s) |-> ##[1:1000] (r.st == S_VEC_HI && r.addr == VEC_RESTART && r.cc[CC_I]);
  endproperty
  a_restart_vector: assert property (p_restart_vector) else $error("no restart fetch");

  property p_nmi_latch;
    tick && r.e && r.nmi_prev && !nmi_s |=> r.nmi_pend;
  endproperty
  a_nmi_latch: assert property (p_nmi_latch) else $error("edge request lost");

  property p_sample_high;
    !(tick && r.e) |=> r.nmi_prev == $past(r.nmi_prev);
  endproperty
  a_sample_high: assert property (p_sample_high) else $error("sampled outside E high");

  property p_flags_ones;
    apb_setup && paddr == OFS_COND_FLAGS |=> prdata[7:6] == CC_TOP_ONES
                                          && prdata[CC_I] == $past(r.cc[CC_I]);
  endproperty
  a_flags_ones: assert property (p_flags_ones) else $error("flag read wrong");

  property p_ram_gate;
    !re_s |-> !(ram_we && r.addr < RAM_LIMIT && r.st == S_PUSH);
  endproperty
  a_ram_gate: assert property (p_ram_gate) else $error("RAM written while disabled");

  property p_stretch;
    tick && r.e && !mw_s |=> r.e;
  endproperty
  a_stretch: assert property (p_stretch) else $error("E not stretched");

  property p_sp_dec;
    r.st == S_PUSH && cycle_end && rst_s && !apb_wr |=> r.sp == $past(r.sp) - 16'h0001;
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("stack not decremented");

endmodule : mbic_core
`default_nettype wire

// >>> rtl/mbic_pkg.sv
/*
  Package for the bus and exception sequencer: APB map, vectors, bus timing,
  state codes and the packed carriers. Assumes a 200 MHz APB clock.
*/
package mbic_pkg;

  // ==========================================================================
  // apb register map (byte addresses)
  localparam logic [11:0] OFS_INSTR_PTR   = 12'h000;
  localparam logic [11:0] OFS_STACK_TOP   = 12'h004;
  localparam logic [11:0] OFS_INDEX_BASE  = 12'h008;
  localparam logic [11:0] OFS_ACC_A       = 12'h00c;
  localparam logic [11:0] OFS_ACC_B       = 12'h010;
  localparam logic [11:0] OFS_COND_FLAGS  = 12'h014;
  localparam logic [11:0] OFS_STATUS      = 12'h018;
  localparam logic [2:0]  RAM_WIN_SEL     = 3'h1;      // paddr[11:9], 0x200..0x3fc

  // ==========================================================================
  // condition flag positions; bits 7:6 always read as one
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_I = 4;
  localparam int CC_H = 5;
  localparam logic [1:0] CC_TOP_ONES = 2'h3;

  // status register fields
  localparam int ST_STATE_LSB = 0;   // 3 bits
  localparam int ST_BA        = 3;
  localparam int ST_VMA       = 4;
  localparam int ST_NMI_PEND  = 5;
  localparam int ST_HALT_REQ  = 6;
  localparam int ST_IRQ_REQ   = 7;

  // ==========================================================================
  // vectors, memory, opcodes
  localparam logic [15:0] VEC_RESTART = 16'hfffe;
  localparam logic [15:0] VEC_NMI     = 16'hfffc;
  localparam logic [15:0] VEC_IRQ     = 16'hfff8;
  localparam logic [15:0] RAM_LIMIT   = 16'h0080;
  localparam int          RAM_DEPTH   = 128;
  localparam logic [2:0]  PUSH_LAST   = 3'h6;
  localparam logic [7:0]  OP_ADD_BA   = 8'h1b;
  localparam logic [7:0]  OP_BR_ZERO  = 8'h27;
  localparam logic [7:0]  OP_WAIT     = 8'h3e;

  // ==========================================================================
  // bus clock timing: each half of the bus clock
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          E_HALF_NS     = 500;
  localparam logic [7:0]  E_HALF_CYC    =
    8'((E_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // synchroniser bit positions
  localparam int SY_HALT = 0;
  localparam int SY_IRQ  = 1;
  localparam int SY_NMI  = 2;
  localparam int SY_RST  = 3;
  localparam int SY_MW   = 4;
  localparam int SY_RE   = 5;
  localparam int SY_DIN  = 6;
  localparam logic [13:0] SYNC_RST = 14'h0017;

  typedef enum logic [2:0] {
    S_RST    = 3'h0,
    S_VEC_HI = 3'h1,
    S_VEC_LO = 3'h2,
    S_FETCH  = 3'h3,
    S_OPER   = 3'h4,
    S_PUSH   = 3'h5,
    S_HALT   = 3'h6,
    S_WAIT   = 3'h7
  } mbic_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        doe;
    logic        rw;
    logic        valid_address_strobe;
    logic        ba;
    logic        e;
  } mbic_bus_s;

  typedef struct packed {
    mbic_state_e st;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] ix;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [5:0]  cc;
    logic        e;
    logic [7:0]  div;
    logic [2:0]  idx;
    logic [15:0] vec;
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        rw;
    logic        valid_address_strobe;
    logic        doe;
    logic        nmi_prev;
    logic        nmi_pend;
    logic [13:0] s1;
    logic [13:0] s2;
    logic [31:0] prdata;
    logic        perr;
  } mbic_regs_s;

endpackage : mbic_pkg

// >>> verification/mbic_mem_model.sv
/*
  memory and peripheral model on the processor bus; logs cycles as they end at the fall of E.
  assumes the mbic_core bus timing on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module mbic_mem_model
  import mbic_pkg::*;
(
  input  wire logic      pclk,
  input  wire mbic_bus_s bus_i,
  input  wire logic      slow,
  output logic           memory_wait_in,
  output logic [7:0]     data_in
);
  // ==========================================================================
  // storage and cycle logs
  logic [7:0]  mem [int];
  logic [15:0] rd_q [$];
  logic [23:0] wr_q [$];
  logic        e_q = 1'b0;
  int          hi_n = 0;
  logic        mw_r = 1'b1;
  logic [7:0]  din_r = 8'h00;

  assign memory_wait_in = mw_r;
  assign data_in        = din_r;

  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'h01;
  endfunction : peek

  always @(posedge pclk) begin
    e_q <= bus_i.e;
    hi_n <= bus_i.e ? hi_n + 1 : 0;
    mw_r <= !slow || hi_n > 150;
    din_r <= (bus_i.valid_address_strobe && bus_i.rw) ? peek(bus_i.addr) : ~din_r;
    if (e_q && !bus_i.e && bus_i.valid_address_strobe) begin
      if (bus_i.rw) begin
        rd_q.push_back(bus_i.addr);
      end else begin
        wr_q.push_back({bus_i.addr, bus_i.dout});
        mem[int'(bus_i.addr)] = bus_i.dout;
      end
    end
  end
endmodule : mbic_mem_model
`default_nettype wire

// >>> verification/tb.sv
/*
  self-checking bench for mbic_core with a bus memory model.
  assumes the apb map, vectors and bus timing of mbic_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mbic_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic        halt_n, irq_n, nmi_n, restart_n, slow, onchip_memory_enable;
  logic        memory_wait_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, v;
  logic [7:0]  data_in, ea, eb, ef;
  logic [8:0]  s;
  logic [4:0]  hs;
  logic [15:0] eix;
  mbic_bus_s   bus_o;
  int          failures, num_checks;

  mbic_core u_mbic_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .halt_n(halt_n),
    .irq_n(irq_n), .nmi_n(nmi_n), .restart_n(restart_n),
    .memory_wait_in(memory_wait_in), .data_in(data_in),
    .onchip_memory_enable(onchip_memory_enable), .bus_o(bus_o));
  mbic_mem_model u_mem (.pclk(pclk), .bus_i(bus_o), .slow(slow),
    .memory_wait_in(memory_wait_in), .data_in(data_in));

  always #2.5 pclk = ~pclk;

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic bit seen(input logic [15:0] a);
    foreach (u_mem.rd_q[i]) if (u_mem.rd_q[i] === a) return 1'b1;
    return 1'b0;
  endfunction : seen

  task automatic wt_ba(input logic b);
    for (int n = 0; n < 2000 && bus_o.ba !== b; n++) @(posedge pclk);
    chk(32'(bus_o.ba), 32'(b));
  endtask : wt_ba

  task automatic vseq(input logic [15:0] a, input logic [15:0] t);
    for (int n = 0; n < 3000 && u_mem.rd_q.size() < 3; n++) @(posedge pclk);
    chk(32'(u_mem.rd_q[0]), 32'(a));
    chk(32'(u_mem.rd_q[1]), 32'(a + 16'h1));
    chk(32'(u_mem.rd_q[2]), 32'(t));
  endtask : vseq

  task automatic setup(input logic [15:0] pc, input logic [15:0] sp,
                       input logic [7:0] a, input logic [7:0] b);
    eix = 16'($urandom);
    ea = a;
    eb = b;
    ef = 8'hc0;
    apb(1'b1, OFS_INSTR_PTR, {16'h0, pc});
    apb(1'b1, OFS_STACK_TOP, {16'h0, sp});
    apb(1'b1, OFS_INDEX_BASE, {16'h0, eix});
    apb(1'b1, OFS_ACC_A, {24'h0, ea});
    apb(1'b1, OFS_ACC_B, {24'h0, eb});
    apb(1'b1, OFS_COND_FLAGS, 32'h0);
  endtask : setup

  task automatic svc(input logic [15:0] sp, input logic [15:0] pc,
                     input logic [15:0] vec, input logic [15:0] t);
    logic [7:0] ew [7];
    ew = '{pc[7:0], pc[15:8], eix[7:0], eix[15:8], ea, eb, ef};
    for (int n = 0; n < 9000 && u_mem.wr_q.size() < 7; n++) @(posedge pclk);
    u_mem.rd_q.delete();
    for (int i = 0; i < 7; i++) begin
      chk(32'(u_mem.wr_q[i]), {8'h0, sp - 16'(i), ew[i]});
    end
    vseq(vec, t);
    u_mem.wr_q.delete();
    ef = ef | 8'h10;
    apb(1'b0, OFS_COND_FLAGS, 32'h0);
    chk(rq, {24'h0, ef});
    apb(1'b0, OFS_STACK_TOP, 32'h0);
    chk(rq, 32'(sp - 16'h7));
  endtask : svc

  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    give_verdict();
  end

  // ==========================================================================
  // scenarios
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    halt_n = 1'b1;
    irq_n = 1'b1;
    nmi_n = 1'b1;
    restart_n = 1'b0;
    slow = 1'b0;
    onchip_memory_enable = 1'b1;
    failures = 0;
    num_checks = 0;
    void'($urandom(32'h50953935));
    u_mem.mem['hfffe] = 8'h01;
    u_mem.mem['hffff] = 8'h00;
    u_mem.mem['hfffc] = 8'h20;
    u_mem.mem['hfffd] = 8'h00;
    u_mem.mem['hfff8] = 8'h22;
    u_mem.mem['hfff9] = 8'h00;
    u_mem.mem['h3000] = OP_WAIT;
    u_mem.mem['h3100] = OP_ADD_BA;
    u_mem.mem['h3101] = OP_BR_ZERO;
    u_mem.mem['h3102] = 8'h10;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'({bus_o.rw, bus_o.valid_address_strobe, bus_o.ba, bus_o.doe}), 32'h8);
    restart_n <= 1'b1;
    vseq(VEC_RESTART, 16'h0100);
    apb(1'b0, OFS_COND_FLAGS, 32'h0);
    chk(rq & 32'hd0, 32'hd0);
    for (int i = 1; i < 5; i++) begin
      v = $urandom & ((i < 3) ? 32'hffff : 32'hff);
      apb(1'b1, 12'(4 * i), v);
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rq, v);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk({rq[30:0], perr}, 32'h1);
    // halted with a non-maskable edge held pending
    halt_n <= 1'b0;
    wt_ba(1'b1);
    chk(32'({bus_o.rw, bus_o.valid_address_strobe, bus_o.doe}), 32'h4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rq, 32'h4e);
    setup(16'h3100, 16'h01ff, 8'($urandom), 8'($urandom));
    nmi_n <= 1'b0;
    repeat (400) @(posedge pclk);
    nmi_n <= 1'b1;
    chk(32'(bus_o.ba), 32'h1);
    halt_n <= 1'b1;
    svc(16'h01ff, 16'h3100, VEC_NMI, 16'h2000);
    for (int i = 0; i < 3; i++) begin
      halt_n <= 1'b0;
      wt_ba(1'b1);
      setup(16'h3100, 16'h0300, (i == 0) ? 8'hff : 8'($urandom),
            (i == 0) ? 8'h01 : 8'($urandom));
      u_mem.rd_q.delete();
      halt_n <= 1'b1;
      for (int n = 0; n < 3000 && !seen(16'h3101); n++) @(posedge pclk);
      s = {1'b0, ea} + {1'b0, eb};
      hs = {1'b0, ea[3:0]} + {1'b0, eb[3:0]};
      ef = {2'b11, hs[4], 1'b0, s[7], s[7:0] == 8'h0,
            (ea[7] == eb[7]) && (s[7] != ea[7]), s[8]};
      apb(1'b0, OFS_ACC_A, 32'h0);
      chk(rq, {24'h0, s[7:0]});
      apb(1'b0, OFS_COND_FLAGS, 32'h0);
      chk(rq, {24'h0, ef});
      v = (s[7:0] == 8'h0) ? 32'h3113 : 32'h3103;
      for (int n = 0; n < 3000 && !seen(16'(v)); n++) @(posedge pclk);
      chk(32'(seen(16'(v ^ 32'h10))), 32'h0);
      chk(32'(seen(16'(v))), 32'h1);
    end
    // wait instruction, masked then unmasked request, slow memory
    halt_n <= 1'b0;
    wt_ba(1'b1);
    setup(16'h3000, 16'h02ff, 8'($urandom), 8'($urandom));
    apb(1'b1, OFS_COND_FLAGS, 32'h10);
    slow <= 1'b1;
    halt_n <= 1'b1;
    wt_ba(1'b0);
    wt_ba(1'b1);
    irq_n <= 1'b0;
    repeat (600) @(posedge pclk);
    chk(32'(bus_o.ba), 32'h1);
    apb(1'b1, OFS_COND_FLAGS, 32'h0);
    svc(16'h02ff, 16'h3001, VEC_IRQ, 16'h2200);
    irq_n <= 1'b1;
    slow <= 1'b0;
    // on-chip memory window
    v = 32'($urandom & 32'hff);
    apb(1'b1, 12'h3fc, v);
    apb(1'b0, 12'h3fc, 32'h0);
    chk(rq, v);
    onchip_memory_enable <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h3fc, ~v);
    chk(32'(perr), 32'h1);
    onchip_memory_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h3fc, 32'h0);
    chk(rq, v);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
